// >>> core/rtc_core_regs.vh
// Register map, field positions, source codes and timing of the RTC core
`ifndef RTC_CORE_REGS_VH
`define RTC_CORE_REGS_VH

// Register addresses
`define ADDR_CTRL_ONE     4'h0
`define ADDR_CTRL_TWO     4'h1
`define ADDR_SECONDS      4'h2
`define ADDR_MINUTES      4'h3
`define ADDR_HOURS        4'h4
`define ADDR_DAYS         4'h5
`define ADDR_WEEKDAYS     4'h6
`define ADDR_MONTHS       4'h7
`define ADDR_YEARS        4'h8
`define ADDR_ALM_MINUTE   4'h9
`define ADDR_ALM_HOUR     4'ha
`define ADDR_ALM_DAY      4'hb
`define ADDR_ALM_WEEKDAY  4'hc
`define ADDR_SQUARE_CTRL  4'hd
`define ADDR_CNT_CTRL     4'he
`define ADDR_CNT_VALUE    4'hf

// Field positions
`define BIT_TEST_SELECT   7
`define BIT_DIV_HALT      5
`define BIT_POR_OVERRIDE  3
`define BIT_PULSE_SELECT  4
`define BIT_ALARM_FLAG    3
`define BIT_CNT_FLAG      2
`define BIT_ALARM_IRQ_EN  1
`define BIT_CNT_IRQ_EN    0
`define BIT_TOP           7

// Source select codes
`define SRC_4096HZ        2'h0
`define SRC_64HZ          2'h1
`define SRC_1HZ           2'h2
`define SRC_60TH_HZ       2'h3
`define SQ_32768HZ        2'h0
`define SQ_1024HZ         2'h1
`define SQ_32HZ           2'h2
`define SQ_1HZ            2'h3

// Divider taps and wrap masks (oscillator ticks)
`define DIV_TAP_1024      4
`define DIV_TAP_32        9
`define DIV_TAP_1         14
`define DIV_MASK_4096     15'h0007
`define DIV_MASK_64       15'h01ff
`define DIV_MASK_1        15'h7fff
`define SEC_PER_MIN       6'h3b

// Timing
`define CLK_PERIOD_NS     25
`define OSC_STOP_NS       100000
`define OSC_STOP_CYCLES   (`OSC_STOP_NS / `CLK_PERIOD_NS)
`define PULSE_OSC_TICKS   4'h8

`endif

// >>> core/rtc_core.v
// Real-time clock/calendar core with alarm, countdown and square output
// Function
// R01: Sixteen byte registers, self-advancing pointer.
// R02: Fixed map: control, time, alarm, square, countdown.
// R03: Time and alarms BCD; weekdays binary.
// R04: Time counters frozen during register access.
// R05: Alarm field top bit is active-low enable.
// R06: Alarm match sets alarm flag, may interrupt.
// R07: Alarm flag cleared only by software.
// R08: Countdown enable and four source rates.
// R09: Binary countdown from loaded byte, flags each end.
// R10: Countdown flag cleared only by software.
// R11: Countdown interrupt pulsed or following flag.
// R12: Countdown value read returns live count.
// R13: Square output 32768, 1024, 32, 1 Hz.
// R14: Square output enabled at reset; off floats.
// R15: Oscillator stopped holds reset, reinitialises bus.
// R16: Reset clears all but listed bits set.
// R17: Supply low sets flag in seconds bit 7.
// R18: Supply-low flag cleared only by software.
// R19: Host writes zero to zero-defined bits.
// R20: Host keeps each access below one second.
// R21: Divider halt clears chain, square 32768 continues.
// R22: Calendar carry with month lengths, leap, century.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_core_regs.vh"

module rtc_core (
  input  wire       clk,           // System clock, 40 MHz
  input  wire       sys_rst,       // Synchronous reset, active high
  input  wire       ce,            // Clock enable, low freezes all state
  input  wire       osc_in,        // 32.768 kHz oscillator, asynchronous
  input  wire       supply_low,    // Low-voltage detector, asynchronous
  input  wire       session_active,// Bus access in progress
  input  wire       ptr_load,      // Load address pointer
  input  wire [3:0] ptr_data,      // New pointer value
  input  wire       wr_stb,        // Write byte at pointer
  input  wire [7:0] wr_data,       // Write data
  input  wire       rd_stb,        // Read byte at pointer
  output reg  [7:0] rd_data,       // Read data, valid after rd_stb
  output reg        bus_reinit,    // Serial logic reset while osc stopped
  output reg        square_out_o,  // Square pin drive level (always 0)
  output reg        square_out_oe, // Square pin pulled low when high
  output reg        irq_o,         // Interrupt pin drive level (always 0)
  output reg        irq_oe         // Interrupt pin pulled low when high
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // BCD increment with wrap from top back to bottom
  function [7:0] bcd_inc;
    input [7:0] v;
    input [7:0] top;
    input [7:0] bottom;
    begin
      if (v == top)
        bcd_inc = bottom;
      else if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last day of month in BCD, years divisible by four are leap
  function [7:0] month_last;
    input [4:0] m;
    input [7:0] y;
    reg         leap;
    begin
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      case (m)
        5'h02:   month_last = leap ? 8'h29 : 8'h28;
        5'h04,
        5'h06,
        5'h09,
        5'h11:   month_last = 8'h30;
        default: month_last = 8'h31;
      endcase
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  reg osc_s1, osc_s2, osc_s3;
  reg low_s1, low_s2;

  // Two flops before any logic looks at a pin
  always @(posedge clk) begin
    if (ce) begin
      osc_s1 <= osc_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      low_s1 <= supply_low;
      low_s2 <= low_s1;
    end
  end

  wire osc_rise = osc_s2 & ~osc_s3;

  // ==========================================================
  // Oscillator stop monitor and internal reset
  // ==========================================================
  reg [11:0] stop_cnt;
  reg        osc_stopped;
  wire       int_rst = sys_rst | osc_stopped;

  // R15: stop watchdog
  // Any edge restarts the watch; no edge for the timeout holds reset
  always @(posedge clk) begin
    if (sys_rst) begin
      stop_cnt    <= 12'h000;
      osc_stopped <= 1'b0;
    end else if (ce) begin
      if (osc_s2 != osc_s3) begin
        stop_cnt    <= 12'h000;
        osc_stopped <= 1'b0;
      end else if (stop_cnt == `OSC_STOP_CYCLES - 1) begin
        osc_stopped <= 1'b1;
      end else begin
        stop_cnt <= stop_cnt + 12'h001;
      end
    end
  end

  // ==========================================================
  // Register storage
  // ==========================================================
  reg [3:0] ptr;
  reg       test_sel, div_halt, por_override;
  reg       pulse_sel, alarm_flag, countdown_flag;
  reg       alarm_irq_en, countdown_irq_en;
  reg       supply_low_flag, century;
  reg [6:0] seconds, minutes;
  reg [5:0] hours, days;
  reg [2:0] weekday;
  reg [4:0] month;
  reg [7:0] year;
  reg [7:0] alm_min, alm_hour, alm_day, alm_wday;
  reg       square_out_en;
  reg [1:0] square_freq_sel;
  reg       countdown_en;
  reg [1:0] countdown_src_sel;
  reg [7:0] countdown_reload, countdown_count;

  wire wr_hit = wr_stb & ~ptr_load;

  // ==========================================================
  // Divider chain and source ticks
  // ==========================================================
  reg [14:0] div;
  reg [5:0]  sec60;

  // R21: halt clears divider
  // Halt and reset hold the chain at zero; under halt raw osc still reaches pin when 32768 Hz is selected
  always @(posedge clk) begin
    if (int_rst || div_halt) begin
      div   <= 15'h0000;
      sec60 <= 6'h00;
    end else if (ce && osc_rise) begin
      div <= div + 15'h0001;
      if (div == `DIV_MASK_1)
        sec60 <= (sec60 == `SEC_PER_MIN) ? 6'h00 : sec60 + 6'h01;
    end
  end

  wire run      = ce & osc_rise & ~div_halt;
  wire sec_tick = run & (div == `DIV_MASK_1);
  reg  src_tick;

  // R08: source rate choice
  always @* begin
    case (countdown_src_sel)
      `SRC_4096HZ: src_tick = run & ((div & `DIV_MASK_4096) == `DIV_MASK_4096);
      `SRC_64HZ:   src_tick = run & ((div & `DIV_MASK_64) == `DIV_MASK_64);
      `SRC_1HZ:    src_tick = sec_tick;
      default:     src_tick = sec_tick & (sec60 == `SEC_PER_MIN);
    endcase
  end

  // ==========================================================
  // Time advance with freeze
  // ==========================================================
  reg  sec_pend;
  // R04: freeze during access
  wire frozen  = session_active;
  wire advance = ce & ~frozen & (sec_tick | sec_pend);

  // Carry chain into the next values
  wire [7:0] next_sec   = bcd_inc({1'b0, seconds}, 8'h59, 8'h00);
  wire [7:0] next_min   = bcd_inc({1'b0, minutes}, 8'h59, 8'h00);
  wire [7:0] next_hour  = bcd_inc({2'b00, hours}, 8'h23, 8'h00);
  wire [7:0] next_day   = bcd_inc({2'b00, days},
                                  month_last(month, year), 8'h01);
  wire [7:0] next_month = bcd_inc({3'b000, month}, 8'h12, 8'h01);
  wire [7:0] next_year  = bcd_inc(year, 8'h99, 8'h00);
  wire c_min   = (seconds == 7'h59);
  wire c_hour  = c_min & (minutes == 7'h59);
  wire c_day   = c_hour & (hours == 6'h23);
  wire c_month = c_day & ({2'b00, days} == month_last(month, year));
  wire c_year  = c_month & (month == 5'h12);

  // A tick seen while frozen is held once and applied on release
  always @(posedge clk) begin
    if (int_rst)
      sec_pend <= 1'b0;
    else if (ce)
      sec_pend <= frozen & (sec_pend | sec_tick);
  end

  // R22: calendar carry
  // R03: BCD time fields
  // Host writes take the register in place of the count
  always @(posedge clk) begin
    if (int_rst) begin
      seconds <= 7'h00;
      minutes <= 7'h00;
      hours   <= 6'h00;
      days    <= 6'h00;
      weekday <= 3'h0;
      month   <= 5'h00;
      century <= 1'b0;
      year    <= 8'h00;
    end else if (ce) begin
      if (advance) begin
        seconds <= next_sec[6:0];
        if (c_min)
          minutes <= next_min[6:0];
        if (c_hour)
          hours <= next_hour[5:0];
        if (c_day) begin
          days    <= next_day[5:0];
          weekday <= (weekday == 3'h6) ? 3'h0 : weekday + 3'h1;
        end
        if (c_month)
          month <= next_month[4:0];
        if (c_year) begin
          year    <= next_year;
          century <= century ^ (year == 8'h99);
        end
      end
      if (wr_hit) begin
        case (ptr)
          `ADDR_SECONDS:  seconds <= wr_data[6:0];
          `ADDR_MINUTES:  minutes <= wr_data[6:0];
          `ADDR_HOURS:    hours   <= wr_data[5:0];
          `ADDR_DAYS:     days    <= wr_data[5:0];
          `ADDR_WEEKDAYS: weekday <= wr_data[2:0];
          `ADDR_MONTHS: begin
            month   <= wr_data[4:0];
            century <= wr_data[`BIT_TOP];
          end
          `ADDR_YEARS:    year <= wr_data;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Alarm match
  // ==========================================================
  // R05: active-low field enables
  wire alm_any = ~alm_min[`BIT_TOP] | ~alm_hour[`BIT_TOP] |
                 ~alm_day[`BIT_TOP] | ~alm_wday[`BIT_TOP];
  wire alm_hit = alm_any &
    (alm_min[`BIT_TOP]  | (alm_min[6:0]  == minutes)) &
    (alm_hour[`BIT_TOP] | (alm_hour[5:0] == hours)) &
    (alm_day[`BIT_TOP]  | (alm_day[5:0]  == days)) &
    (alm_wday[`BIT_TOP] | (alm_wday[2:0] == weekday));
  reg  alm_hit_q;
  // Flag on entry to the match only, so a clear stays cleared
  wire alm_event = alm_hit & ~alm_hit_q;

  // ==========================================================
  // Countdown timer
  // ==========================================================
  reg  [3:0] pulse_cnt;
  wire       cnt_done = countdown_en & src_tick &
                        (countdown_count <= 8'h01) &
                        (countdown_reload != 8'h00);

  // R09: binary countdown
  // R12: live count kept
  always @(posedge clk) begin
    if (int_rst) begin
      countdown_count <= 8'h00;
      pulse_cnt       <= 4'h0;
      alm_hit_q       <= 1'b0;
    end else if (ce) begin
      alm_hit_q <= alm_hit;
      if (wr_hit && ptr == `ADDR_CNT_VALUE)
        countdown_count <= wr_data;
      else if (cnt_done)
        countdown_count <= countdown_reload;
      else if (countdown_en && src_tick && countdown_count != 8'h00)
        countdown_count <= countdown_count - 8'h01;
      // R11: pulse stretch
      if (cnt_done)
        pulse_cnt <= `PULSE_OSC_TICKS;
      else if (osc_rise && pulse_cnt != 4'h0)
        pulse_cnt <= pulse_cnt - 4'h1;
    end
  end

  // ==========================================================
  // Control registers and sticky flags
  // ==========================================================
  // R16: reset values
  // R06: alarm flag set
  // R07: software-only alarm clear
  // R10: software-only countdown clear
  // R18: software-only supply-low clear
  // Set beats clear when both land in one cycle
  always @(posedge clk) begin
    if (int_rst) begin
      test_sel          <= 1'b0;
      div_halt          <= 1'b0;
      por_override      <= 1'b1;
      pulse_sel         <= 1'b0;
      alarm_flag        <= 1'b0;
      countdown_flag    <= 1'b0;
      alarm_irq_en      <= 1'b0;
      countdown_irq_en  <= 1'b0;
      supply_low_flag   <= 1'b1;
      alm_min           <= 8'h80;
      alm_hour          <= 8'h80;
      alm_day           <= 8'h80;
      alm_wday          <= 8'h80;
      square_out_en     <= 1'b1;
      square_freq_sel   <= `SQ_32768HZ;
      countdown_en      <= 1'b0;
      countdown_src_sel <= `SRC_60TH_HZ;
      countdown_reload  <= 8'h00;
    end else if (ce) begin
      if (wr_hit) begin
        case (ptr)
          `ADDR_CTRL_ONE: begin
            test_sel     <= wr_data[`BIT_TEST_SELECT];
            div_halt     <= wr_data[`BIT_DIV_HALT];
            por_override <= wr_data[`BIT_POR_OVERRIDE];
          end
          `ADDR_CTRL_TWO: begin
            pulse_sel        <= wr_data[`BIT_PULSE_SELECT];
            alarm_irq_en     <= wr_data[`BIT_ALARM_IRQ_EN];
            countdown_irq_en <= wr_data[`BIT_CNT_IRQ_EN];
            if (!wr_data[`BIT_ALARM_FLAG])
              alarm_flag <= 1'b0;
            if (!wr_data[`BIT_CNT_FLAG])
              countdown_flag <= 1'b0;
          end
          `ADDR_SECONDS:     supply_low_flag <= wr_data[`BIT_TOP];
          `ADDR_ALM_MINUTE:  alm_min  <= wr_data;
          `ADDR_ALM_HOUR:    alm_hour <= {wr_data[7], 1'b0, wr_data[5:0]};
          `ADDR_ALM_DAY:     alm_day  <= {wr_data[7], 1'b0, wr_data[5:0]};
          `ADDR_ALM_WEEKDAY: alm_wday <= {wr_data[7], 4'h0, wr_data[2:0]};
          `ADDR_SQUARE_CTRL: begin
            square_out_en   <= wr_data[`BIT_TOP];
            square_freq_sel <= wr_data[1:0];
          end
          `ADDR_CNT_CTRL: begin
            countdown_en      <= wr_data[`BIT_TOP];
            countdown_src_sel <= wr_data[1:0];
          end
          `ADDR_CNT_VALUE:   countdown_reload <= wr_data;
          default: ;
        endcase
      end
      if (alm_event)
        alarm_flag <= 1'b1;
      if (cnt_done)
        countdown_flag <= 1'b1;
      // R17: supply-low detection
      if (low_s2)
        supply_low_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Address pointer and read port
  // ==========================================================
  reg [7:0] rd_mux;

  // R02: register map
  // Unimplemented bits read as zero
  always @* begin
    case (ptr)
      `ADDR_CTRL_ONE:    rd_mux = {test_sel, 1'b0, div_halt, 1'b0,
                                   por_override, 3'h0};
      `ADDR_CTRL_TWO:    rd_mux = {3'h0, pulse_sel, alarm_flag,
                                   countdown_flag, alarm_irq_en,
                                   countdown_irq_en};
      `ADDR_SECONDS:     rd_mux = {supply_low_flag, seconds};
      `ADDR_MINUTES:     rd_mux = {1'b0, minutes};
      `ADDR_HOURS:       rd_mux = {2'h0, hours};
      `ADDR_DAYS:        rd_mux = {2'h0, days};
      `ADDR_WEEKDAYS:    rd_mux = {5'h00, weekday};
      `ADDR_MONTHS:      rd_mux = {century, 2'h0, month};
      `ADDR_YEARS:       rd_mux = year;
      `ADDR_ALM_MINUTE:  rd_mux = alm_min;
      `ADDR_ALM_HOUR:    rd_mux = alm_hour;
      `ADDR_ALM_DAY:     rd_mux = alm_day;
      `ADDR_ALM_WEEKDAY: rd_mux = alm_wday;
      `ADDR_SQUARE_CTRL: rd_mux = {square_out_en, 5'h00, square_freq_sel};
      `ADDR_CNT_CTRL:    rd_mux = {countdown_en, 5'h00, countdown_src_sel};
      default:           rd_mux = countdown_count;
    endcase
  end

  // R01: pointer auto-advance
  // Four-bit pointer wraps from the last register back to the first
  always @(posedge clk) begin
    if (int_rst) begin
      ptr     <= 4'h0;
      rd_data <= 8'h00;
    end else if (ce) begin
      if (ptr_load) begin
        ptr <= ptr_data;
      end else if (rd_stb) begin
        rd_data <= rd_mux;
        ptr     <= ptr + 4'h1;
      end else if (wr_stb) begin
        ptr <= ptr + 4'h1;
      end
    end
  end

  // ==========================================================
  // Pin outputs
  // ==========================================================
  reg sq_wave;

  // R13: square frequency select
  always @* begin
    case (square_freq_sel)
      `SQ_32768HZ: sq_wave = osc_s2;
      `SQ_1024HZ:  sq_wave = div[`DIV_TAP_1024];
      `SQ_32HZ:    sq_wave = div[`DIV_TAP_32];
      default:     sq_wave = div[`DIV_TAP_1];
    endcase
  end

  // R14: enable and float
  // R11: pulse or level interrupt
  // R15: bus reinit during stop
  // Open-drain pins only ever pull low, so drive level stays zero
  always @(posedge clk) begin
    if (sys_rst) begin
      square_out_o  <= 1'b0;
      square_out_oe <= 1'b0;
      irq_o         <= 1'b0;
      irq_oe        <= 1'b0;
      bus_reinit    <= 1'b1;
    end else if (ce) begin
      square_out_o  <= 1'b0;
      square_out_oe <= square_out_en & ~sq_wave & ~osc_stopped;
      irq_o         <= 1'b0;
      irq_oe        <= (alarm_flag & alarm_irq_en) |
                       (countdown_irq_en &
                        (pulse_sel ? (pulse_cnt != 4'h0)
                                   : countdown_flag));
      bus_reinit    <= osc_stopped;
    end
  end

endmodule
`default_nettype wire

// >>> dv/osc_source.sv
// Stand-in for the 32.768 kHz crystal feeding the RTC core
`timescale 1ns/1ps
`default_nettype none

module osc_source (
  input  wire logic run, // High lets the crystal swing
  output var  logic osc  // Oscillator pin, 200 ns period
);
  // Free-running swing; a stopped crystal holds its last level
  initial begin
    osc = 1'b0;
    #7;
    forever begin
      #100;
      if (run) osc = ~osc;
    end
  end
endmodule

`default_nettype wire

// >>> dv/rtc_core_monitor.sv
// Port-level assertions for the RTC core
`timescale 1ns/1ps
`default_nettype none
`include "rtc_core_regs.vh"

module rtc_core_monitor (
  input wire logic       clk,           // System clock
  input wire logic       sys_rst,       // Synchronous reset
  input wire logic       osc_in,        // Oscillator pin
  input wire logic       rd_stb,        // Read strobe
  input wire logic [7:0] rd_data,       // Read data
  input wire logic       bus_reinit,    // Bus logic reset level
  input wire logic       square_out_o,  // Square drive level
  input wire logic       square_out_oe, // Square pull enable
  input wire logic       irq_o,         // Irq drive level
  input wire logic       irq_oe         // Irq pull enable
);
  // Margin covers the synchroniser delay
  localparam int STOP_LIM = `OSC_STOP_CYCLES + 8;
  int   idle_cnt = 0;
  logic osc_q    = 1'b0;

  // =====================
  // Oscillator idle count
  always_ff @(posedge clk) begin
    osc_q <= osc_in;
    if (osc_q != osc_in) idle_cnt <= 0;
    else if (idle_cnt < 100000) idle_cnt <= idle_cnt + 1;
  end

  // =====================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_release;
    $fell(sys_rst);
  endsequence
  sequence s_square_swing;
    ##[1:40] square_out_oe ##[1:40] !square_out_oe;
  endsequence

  a_read_hold: assert property (
    !rd_stb && !bus_reinit ##1 !bus_reinit |-> $stable(rd_data))
    else $error("read data moved without a read strobe");
  a_reset_reinit: assert property (
    disable iff (1'b0) sys_rst |=> bus_reinit)
    else $error("bus reinit low during reset");
  a_reset_quiet: assert property (
    disable iff (1'b0) sys_rst |=>
      !square_out_oe && !irq_oe && rd_data == 8'h00)
    else $error("outputs not quiet during reset");
  a_release_run: assert property (
    disable iff (1'b0) s_release |=> !bus_reinit)
    else $error("bus reinit stuck after reset release");
  a_stop_reinit: assert property (
    idle_cnt > STOP_LIM |-> bus_reinit)
    else $error("stopped oscillator without bus reinit");
  a_drive_low: assert property (
    square_out_o == 1'b0 && irq_o == 1'b0)
    else $error("open drain pin driven high");
  a_square_boot: assert property (
    s_release |-> s_square_swing)
    else $error("square output idle after reset");
  a_reinit_irq_off: assert property (
    bus_reinit ##1 bus_reinit |-> !irq_oe)
    else $error("interrupt asserted during internal reset");
endmodule

bind rtc_core rtc_core_monitor i_rtc_core_monitor (
  .clk(clk), .sys_rst(sys_rst), .osc_in(osc_in), .rd_stb(rd_stb),
  .rd_data(rd_data), .bus_reinit(bus_reinit),
  .square_out_o(square_out_o), .square_out_oe(square_out_oe),
  .irq_o(irq_o), .irq_oe(irq_oe));

`default_nettype wire

// >>> dv/rtc_core_test.sv
// Self-checking testbench for the RTC core
`timescale 1ns/1ps
`default_nettype none

module rtc_core_test;
  logic       clk = 1'b0;            // 40 MHz
  logic       sys_rst = 1'b1;        // Held six cycles
  logic       osc_run = 1'b1;        // Crystal running
  wire        osc_in;                // Oscillator pin
  logic       supply_low = 1'b0;     // Detector level
  logic       session_active = 1'b0; // Host access
  logic       ptr_load = 1'b0;       // Pointer load
  logic [3:0] ptr_data = 4'h0;       // Pointer value
  logic       wr_stb = 1'b0;         // Write strobe
  logic [7:0] wr_data = 8'h00;       // Write byte
  logic       rd_stb = 1'b0;         // Read strobe
  wire  [7:0] rd_data;               // Read byte
  wire        bus_reinit, square_out_o, square_out_oe, irq_o, irq_oe;
  int         num_errors = 0;
  int         check_count = 0;
  logic [7:0] v;
  int         per;
  // Expected periods in clk cycles; one osc period is 8 cycles
  int         sq_per[4] = '{8, 256, 8192, 0};
  int         sq_lim[4] = '{20, 300, 9000, 4500};
  int         cd_per[4] = '{192, 4096, 0, 0};
  int         cd_lim[4] = '{300, 4500, 4500, 4500};
  logic [7:0] cd_ld[4] = '{8'h03, 8'h01, 8'h02, 8'h02};

  osc_source i_osc_source (.run(osc_run), .osc(osc_in));

  rtc_core i_rtc_core (
    .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .osc_in(osc_in),
    .supply_low(supply_low), .session_active(session_active),
    .ptr_load(ptr_load), .ptr_data(ptr_data), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
    .bus_reinit(bus_reinit), .square_out_o(square_out_o),
    .square_out_oe(square_out_oe), .irq_o(irq_o), .irq_oe(irq_oe));

  // Clock generator
  always #12.5 clk = ~clk;

  // =====================
  // Helpers
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Short session per byte keeps the counters frozen briefly
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    session_active <= 1'b1;
    ptr_load <= 1'b1;
    ptr_data <= a;
    @(posedge clk);
    ptr_load <= 1'b0;
    wr_stb <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    session_active <= 1'b0;
  endtask

  task automatic rdc(string what, logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    session_active <= 1'b1;
    ptr_load <= 1'b1;
    ptr_data <= a;
    @(posedge clk);
    ptr_load <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    session_active <= 1'b0;
    #1 v = rd_data;
    chk(what, v, e);
  endtask

  // Rise-to-rise period of irq or square enable, 0 when quiet
  task automatic meas(bit sel, int lim, output int p);
    int   k;
    logic prev, cur;
    p = 0;
    k = 0;
    prev = 1'b1;
    for (int n = 0; n < 2 * lim && k < 2; n++) begin
      @(posedge clk);
      #1 cur = sel ? irq_oe : square_out_oe;
      if (k == 1) p++;
      if (cur === 1'b1 && prev === 1'b0) k++;
      prev = cur;
    end
    if (k < 2) p = 0;
  endtask

  // Bounded wait for irq (sel 0) or bus reinit (sel 1) to reach lvl
  task automatic wait_sig(bit sel, logic lvl, int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if ((sel ? bus_reinit : irq_oe) === lvl) return;
    end
    chk("wait level", sel ? bus_reinit : irq_oe, lvl);
    finish_test();
  endtask

  function automatic logic [7:0] rst_val(logic [3:0] a);
    if (a == 4'h0) return 8'h08;
    if (a == 4'he) return 8'h03;
    if (a == 4'h2 || (a >= 4'h9 && a <= 4'hd)) return 8'h80;
    return 8'h00;
  endfunction

  // =====================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    session_active <= 1'b1;
    ptr_load <= 1'b1;
    @(posedge clk);
    ptr_load <= 1'b0;
    rd_stb <= 1'b1;
    // Burst of 17 reads walks the whole map and wraps
    for (int i = 0; i < 17; i++) begin
      @(posedge clk);
      if (i == 16) rd_stb <= 1'b0;
      if (i == 16) session_active <= 1'b0;
      #1 chk("reset map", rd_data, rst_val(i[3:0]));
    end
    $display("test reset map done");

    wr(4'h2, 8'h00);
    rdc("seconds", 4'h2, 8'h00);
    supply_low <= 1'b1;
    repeat (5) @(posedge clk);
    supply_low <= 1'b0;
    rdc("seconds", 4'h2, 8'h80);
    rdc("seconds", 4'h2, 8'h80);
    $display("test supply low done");

    wr(4'h1, 8'h02);
    wr(4'h9, 8'h00);
    rdc("ctrl2", 4'h1, 8'h0a);
    chk("irq", irq_oe, 1'b1);
    wr(4'h9, 8'h80);
    rdc("ctrl2", 4'h1, 8'h0a);
    wr(4'h1, 8'h02);
    rdc("ctrl2", 4'h1, 8'h02);
    chk("irq", irq_oe, 1'b0);
    wr(4'h6, 8'h05);
    wr(4'h9, 8'h07);
    wr(4'hc, 8'h05);
    rdc("ctrl2", 4'h1, 8'h02);
    wr(4'h9, 8'h80);
    rdc("ctrl2", 4'h1, 8'h0a);
    wr(4'h1, 8'h00);
    wr(4'hc, 8'h80);
    $display("test alarm done");

    wr(4'h1, 8'h01);
    wr(4'hf, 8'h03);
    wr(4'he, 8'h80);
    wait_sig(1'b0, 1'b1, 400);
    rdc("ctrl2", 4'h1, 8'h05);
    repeat (300) @(posedge clk);
    #1 chk("irq level", irq_oe, 1'b1);
    wr(4'h1, 8'h05);
    rdc("ctrl2", 4'h1, 8'h05);
    wr(4'he, 8'h03);
    wr(4'h1, 8'h01);
    rdc("ctrl2", 4'h1, 8'h01);
    chk("irq", irq_oe, 1'b0);
    wr(4'hf, 8'hff);
    wr(4'he, 8'h80);
    // 640 enabled cycles hold exactly ten ticks
    repeat (637) @(posedge clk);
    wr(4'he, 8'h00);
    rdc("live count", 4'hf, 8'hf5);
    chk("live count", v > 8'hf0 && v < 8'hff, 1'b1);
    $display("test countdown done");

    wr(4'h1, 8'h11);
    for (int i = 0; i < 4; i++) begin
      wr(4'hf, cd_ld[i]);
      wr(4'he, 8'h80 | i[7:0]);
      meas(1'b1, cd_lim[i], per);
      chk("countdown period", per[15:0], cd_per[i][15:0]);
      if (i == 0) begin
        repeat (70) @(posedge clk);
        #1 chk("irq pulse", irq_oe, 1'b0);
        rdc("ctrl2", 4'h1, 8'h15);
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'hd, 8'h80 | i[7:0]);
      meas(1'b0, sq_lim[i], per);
      chk("square period", per[15:0], sq_per[i][15:0]);
    end
    wr(4'hd, 8'h00);
    meas(1'b0, 300, per);
    chk("square off", {per[15:0] | square_out_oe}, 16'h0000);
    wr(4'hd, 8'h80);
    $display("test rates done");

    wr(4'hf, 8'h03);
    wr(4'he, 8'h80);
    // Zero-defined control bits are written as zero
    wr(4'h0, 8'h20);
    meas(1'b1, 300, per);
    chk("halted countdown", per[15:0], 16'h0000);
    meas(1'b0, 20, per);
    chk("halted square", per[15:0], 16'h0008);
    wr(4'h0, 8'h00);
    $display("test halt done");

    wr(4'h1, 8'h02);
    osc_run <= 1'b0;
    repeat (4400) @(posedge clk);
    #1 chk("bus reinit", bus_reinit, 1'b1);
    osc_run <= 1'b1;
    wait_sig(1'b1, 1'b0, 200);
    repeat (4) @(posedge clk);
    rdc("ctrl2", 4'h1, 8'h00);
    rdc("countdown ctrl", 4'he, 8'h03);
    rdc("seconds", 4'h2, 8'h80);
    $display("test oscillator stop done");
    finish_test();
  end
endmodule

`default_nettype wire
